// *** rtl/addr_dec_cfg.svh ***
/*
 Address map constants for the address space decoder.
 Assumes inclusion by bare name from rtl/ files; definitions only.
*/
`ifndef ADDR_DEC_CFG_SVH
`define ADDR_DEC_CFG_SVH

// Register file geometry
`define REGF_AW          12
`define CTRL_BASE        12'hf00
`define RAM_BASE         12'h000
`define RAM_BYTES_DEF    1024
`define RAM_BYTES_MIN    256
`define RAM_BYTES_MAX    1024

// Program memory geometry
`define PROG_AW          16
`define FLASH_BYTES_DEF  8192
`define FLASH_BYTES_MIN  1024
`define FLASH_BYTES_MAX  8192
`define BLANK_BYTE       8'hff

// Fixed vector locations
`define OPTION_BASE      16'h0000
`define RESET_VEC_BASE   16'h0002
`define WATCHDOG_VEC     16'h0004
`define ILLEGAL_TRAP     16'h0006
`define IRQ_VEC_BASE     16'h0008
`define IRQ_VEC_LAST     16'h0037
`define OSC_TRAP_BASE    16'h0038
`define OSC_TRAP_LAST    16'h003d
`define CODE_BASE        16'h003e

// Information area overlay
`define INFO_BASE        16'hfe00
`define INFO_LAST        16'hff7f
`define INFO_BYTES       128
`define INFO_AW          7
`define INFO_EN_BIT      7
`define PART_BASE        7'h40
`define PART_LAST        7'h53
`define PART_PAD         8'h0f
`define RSVD_BASE        7'h54
`define RSVD_LAST        7'h5f

`endif

// *** rtl/addr_dec_pkg.sv ***
/*
 Types shared by the address space decoder files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package addr_dec_pkg;
  // Region that a program address falls in
  typedef enum logic [2:0] {
    PR_OPTION,
    PR_VECTOR,
    PR_CODE,
    PR_BLANK,
    PR_INFO
  } prog_region_e;
  // Region of a register file address
  typedef enum logic [1:0] {
    RR_RAM,
    RR_HOLE,
    RR_CTRL
  } regf_region_e;
endpackage

// *** rtl/byte_ram.sv ***
/*
 Single-port byte memory with registered read data.
 Assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module byte_ram #(
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          srst,
  // Access port
  input  wire logic [AW-1:0] addr,
  input  wire logic          wrEn,
  input  wire logic [7:0]    wrData,
  output logic      [7:0]    rdData
);
  initial
  begin
    if (DEPTH > (1 << AW) || DEPTH < 1)
      $error("byte_ram: DEPTH does not fit AW");
  end

  // Storage array
  logic [7:0] mem [DEPTH];
  logic [7:0] rdData_ff;
  logic [7:0] nxt_rdData;

  // Read data selection
  always_comb
  begin
    nxt_rdData = mem[addr];
  end

  // Write and registered read
  always_ff @(posedge ref_clk)
  begin
    if (wrEn)
      mem[addr] <= wrData;
    if (srst)
      rdData_ff <= 8'h00;
    else
      rdData_ff <= nxt_rdData;
  end

  assign rdData = rdData_ff;
endmodule
`default_nettype wire

// *** rtl/info_rom.sv ***
/*
 Read-only information area: option bytes, part string, calibration.
 Contents are constants; nothing can write them.
*/
`timescale 1ns/1ns
`default_nettype none
`include "addr_dec_cfg.svh"
module info_rom #(
  parameter logic [159:0] PART_STRING = {"ADDRDEC01", {11{8'h0f}}},
  parameter logic [7:0]   OPTION_FILL = 8'hff,
  parameter logic [7:0]   CALIB_FILL  = 8'h80
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // Read port
  input  wire logic [6:0] addr,
  output logic      [7:0] rdData
);
  // Part string and defaults are arbitrary values
  logic [7:0] rdData_ff;
  logic [7:0] nxt_rdData;

  // Byte lookup, string is left justified
  always_comb
  begin
    if (addr < `PART_BASE)
      nxt_rdData = OPTION_FILL;
    else if (addr <= `PART_LAST)
      nxt_rdData = PART_STRING[8*(19 - (addr - `PART_BASE)) +: 8];
    else if (addr <= `RSVD_LAST)
      nxt_rdData = 8'hff;
    else
      nxt_rdData = CALIB_FILL;
  end

  // Registered read data
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      rdData_ff <= 8'h00;
    else
      rdData_ff <= nxt_rdData;
  end

  assign rdData = rdData_ff;
endmodule
`default_nettype wire

// *** rtl/address_space_decoder.sv ***
/*
 Address space decoder between the core and RAM, control registers,
 program Flash and the information area.
 Assumes the core holds address and strobes for one cycle per access
 and takes read data two cycles later.
*/
`timescale 1ns/1ns
`default_nettype none
`include "addr_dec_cfg.svh"
module address_space_decoder #(
  parameter int RAM_BYTES   = `RAM_BYTES_DEF,
  parameter int FLASH_BYTES = `FLASH_BYTES_DEF
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Register file access from the core
  input  wire logic [11:0] regAddr,
  input  wire logic        regRd,
  input  wire logic        regWr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  // Control register side
  output logic             ctrlSel,
  output logic             ctrlWr,
  output logic      [7:0]  ctrlAddr,
  output logic      [7:0]  ctrlWrData,
  input  wire logic [7:0]  ctrlRdData,
  // Program memory access from the core
  input  wire logic [15:0] progAddr,
  input  wire logic        progRd,
  input  wire logic        progWr,
  input  wire logic [7:0]  progWrData,
  output logic      [7:0]  progRdData,
  // Flash array side
  output logic             flashWr,
  output logic      [12:0] flashAddr,
  output logic      [7:0]  flashWrData,
  input  wire logic [7:0]  flashRdData,
  // Page select byte from the Flash controller
  input  wire logic [7:0]  pageSelect,
  // Data memory access from the core
  input  wire logic [15:0] dataAddr,
  input  wire logic        dataRd,
  input  wire logic        dataWr,
  output logic      [7:0]  dataRdData,
  // Region code of the program address presented two cycles before
  output logic      [2:0]  progRegion
);
  initial
  begin
    if (RAM_BYTES < `RAM_BYTES_MIN || RAM_BYTES > `RAM_BYTES_MAX)
      $error("RAM_BYTES out of range");
    if (FLASH_BYTES < `FLASH_BYTES_MIN || FLASH_BYTES > `FLASH_BYTES_MAX)
      $error("FLASH_BYTES out of range");
  end

  // Limits widened to the address widths
  localparam logic [11:0] RAM_TOP   = 12'(RAM_BYTES);
  localparam logic [16:0] FLASH_TOP = 17'(FLASH_BYTES);

  // Register file region of an address
  function automatic addr_dec_pkg::regf_region_e regf_region(
    input logic [11:0] a
  );
    if (a >= `CTRL_BASE)
      regf_region = addr_dec_pkg::RR_CTRL;
    else if (a < RAM_TOP)
      regf_region = addr_dec_pkg::RR_RAM;
    else
      regf_region = addr_dec_pkg::RR_HOLE;
  endfunction

  // Program region of an address, given overlay state
  function automatic addr_dec_pkg::prog_region_e prog_region(
    input logic [15:0] a,
    input logic        ovl
  );
    if (ovl && a >= `INFO_BASE && a <= `INFO_LAST)
      prog_region = addr_dec_pkg::PR_INFO;
    else if ({1'b0, a} >= FLASH_TOP)
      prog_region = addr_dec_pkg::PR_BLANK;
    else if (a < `RESET_VEC_BASE)
      prog_region = addr_dec_pkg::PR_OPTION;
    else if (a < `CODE_BASE)
      prog_region = addr_dec_pkg::PR_VECTOR;
    else
      prog_region = addr_dec_pkg::PR_CODE;
  endfunction

  // Decoded request for this cycle
  addr_dec_pkg::regf_region_e regSel;
  addr_dec_pkg::prog_region_e progSel;
  logic                       overlayOn;
  logic                       ramWr;
  logic [7:0]                 ramRdData;
  logic [7:0]                 infoRdData;

  always_comb
  begin
    overlayOn = pageSelect[`INFO_EN_BIT];
    regSel    = regf_region(regAddr);
    progSel   = prog_region(progAddr, overlayOn);
    ramWr     = regWr && (regSel == addr_dec_pkg::RR_RAM);
  end

  // On-chip RAM
  byte_ram #(
    .DEPTH (RAM_BYTES),
    .AW    (10)
  ) u_ram (
    .ref_clk (ref_clk),
    .srst    (srst),
    .addr    (regAddr[9:0]),
    .wrEn    (ramWr),
    .wrData  (regWrData),
    .rdData  (ramRdData)
  );

  // Information area contents
  info_rom u_info (
    .ref_clk (ref_clk),
    .srst    (srst),
    .addr    (progAddr[6:0]),
    .rdData  (infoRdData)
  );

  // Registered strobes toward control registers and Flash
  logic        ctrlSel_ff,     nxt_ctrlSel;
  logic        ctrlWr_ff,      nxt_ctrlWr;
  logic [7:0]  ctrlAddr_ff,    nxt_ctrlAddr;
  logic [7:0]  ctrlWrData_ff,  nxt_ctrlWrData;
  logic        flashWr_ff,     nxt_flashWr;
  logic [12:0] flashAddr_ff,   nxt_flashAddr;
  logic [7:0]  flashWrData_ff, nxt_flashWrData;

  // Strobe decode
  always_comb
  begin
    nxt_ctrlSel     = (regRd || regWr) &&
                      (regSel == addr_dec_pkg::RR_CTRL);
    // Reserved control writes pass on; core must avoid them
    nxt_ctrlWr      = regWr && (regSel == addr_dec_pkg::RR_CTRL);
    nxt_ctrlAddr    = regAddr[7:0];
    nxt_ctrlWrData  = regWrData;
    // Writes beyond Flash or into the overlay never reach the array
    nxt_flashWr     = progWr &&
                      (progSel != addr_dec_pkg::PR_BLANK) &&
                      (progSel != addr_dec_pkg::PR_INFO);
    nxt_flashAddr   = progAddr[12:0];
    nxt_flashWrData = progWrData;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ctrlSel_ff     <= 1'b0;
      ctrlWr_ff      <= 1'b0;
      ctrlAddr_ff    <= 8'h00;
      ctrlWrData_ff  <= 8'h00;
      flashWr_ff     <= 1'b0;
      flashAddr_ff   <= 13'h0000;
      flashWrData_ff <= 8'h00;
    end
    else
    begin
      ctrlSel_ff     <= nxt_ctrlSel;
      ctrlWr_ff      <= nxt_ctrlWr;
      ctrlAddr_ff    <= nxt_ctrlAddr;
      ctrlWrData_ff  <= nxt_ctrlWrData;
      flashWr_ff     <= nxt_flashWr;
      flashAddr_ff   <= nxt_flashAddr;
      flashWrData_ff <= nxt_flashWrData;
    end
  end

  // Read source remembered for the data cycle
  addr_dec_pkg::regf_region_e regSrc_ff,  nxt_regSrc;
  addr_dec_pkg::prog_region_e progSrc_ff, nxt_progSrc;

  always_comb
  begin
    nxt_regSrc  = regSel;
    nxt_progSrc = progSel;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      regSrc_ff  <= addr_dec_pkg::RR_HOLE;
      progSrc_ff <= addr_dec_pkg::PR_BLANK;
    end
    else
    begin
      regSrc_ff  <= nxt_regSrc;
      progSrc_ff <= nxt_progSrc;
    end
  end

  // Overlay bytes past the information area read as blank
  logic infoHigh_ff;  // Last program address had bit 8 or 7 set (FE80-FF7F in overlay)
  logic nxt_infoHigh; // Next value of the flag

  // Information area holds 128 bytes; the rest of the overlay is blank
  always_comb
  begin
    nxt_infoHigh = progAddr[8] | progAddr[7];
  end

  // Flag follows the address every cycle, like the region register
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      infoHigh_ff <= 1'b0;
    else
      infoHigh_ff <= nxt_infoHigh;
  end

  // Read data registers, one cycle after the data cycle
  logic [7:0] regRdData_ff,  nxt_regRdData;
  logic [7:0] progRdData_ff, nxt_progRdData;
  logic [7:0] dataRdData_ff, nxt_dataRdData;
  logic [2:0] progRegion_ff, nxt_progRegion;

  // Read data steering
  always_comb
  begin
    case (regSrc_ff)
      addr_dec_pkg::RR_RAM:  nxt_regRdData = ramRdData;
      addr_dec_pkg::RR_CTRL: nxt_regRdData = ctrlRdData;
      // Undefined per map; blank byte chosen
      addr_dec_pkg::RR_HOLE: nxt_regRdData = `BLANK_BYTE;
      default:               nxt_regRdData = `BLANK_BYTE;
    endcase
    case (progSrc_ff)
      addr_dec_pkg::PR_INFO:
        // Only the low 128 overlay bytes come from the area
        nxt_progRdData = infoHigh_ff ? `BLANK_BYTE : infoRdData;
      addr_dec_pkg::PR_BLANK: nxt_progRdData = `BLANK_BYTE;
      default:                nxt_progRdData = flashRdData;
    endcase
    nxt_dataRdData = `BLANK_BYTE;
    nxt_progRegion = 3'(progSrc_ff);
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      regRdData_ff  <= 8'h00;
      progRdData_ff <= 8'h00;
      dataRdData_ff <= 8'h00;
      progRegion_ff <= 3'h0;
    end
    else
    begin
      regRdData_ff  <= nxt_regRdData;
      progRdData_ff <= nxt_progRdData;
      dataRdData_ff <= nxt_dataRdData;
      progRegion_ff <= nxt_progRegion;
    end
  end

  // Data memory strobes deliberately unused: no storage behind them
  logic dataIgnored;
  always_comb
  begin
    dataIgnored = dataRd | dataWr | (|dataAddr);
  end

  // Outputs straight from flip-flops
  assign regRdData   = regRdData_ff;
  assign ctrlSel     = ctrlSel_ff;
  assign ctrlWr      = ctrlWr_ff;
  assign ctrlAddr    = ctrlAddr_ff;
  assign ctrlWrData  = ctrlWrData_ff;
  assign progRdData  = progRdData_ff;
  assign flashWr     = flashWr_ff;
  assign flashAddr   = flashAddr_ff;
  assign flashWrData = flashWrData_ff;
  assign dataRdData  = dataRdData_ff;
  assign progRegion  = progRegion_ff;
endmodule
`default_nettype wire

// *** tb/addr_dec_props.sv ***
/*
 Port checker for the address space decoder.
 Assumes binding onto address_space_decoder, one clock, sync reset.
*/
`timescale 1ns/1ns
`default_nettype none
module addr_dec_props #(
  parameter int RAM_BYTES   = 1024,
  parameter int FLASH_BYTES = 8192
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        srst,
  // Register file side
  input wire logic [11:0] regAddr,
  input wire logic        regRd,
  input wire logic        regWr,
  input wire logic [7:0]  regWrData,
  input wire logic [7:0]  regRdData,
  input wire logic        ctrlSel,
  input wire logic        ctrlWr,
  input wire logic [7:0]  ctrlAddr,
  input wire logic [7:0]  ctrlWrData,
  input wire logic [7:0]  ctrlRdData,
  // Program side
  input wire logic [15:0] progAddr,
  input wire logic        progRd,
  input wire logic        progWr,
  input wire logic [7:0]  progRdData,
  input wire logic        flashWr,
  input wire logic [12:0] flashAddr,
  input wire logic [7:0]  flashRdData,
  input wire logic [7:0]  pageSelect,
  input wire logic [7:0]  dataRdData
);
  // Request lands in the live overlay window
  logic ovl;
  logic big;
  logic ctl;
  assign ovl = pageSelect[7] && progAddr >= 16'hfe00 && progAddr <= 16'hff7f;
  assign big = 32'(progAddr) >= FLASH_BYTES;
  assign ctl = regAddr[11:8] == 4'hf;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  ctrl_sel_a: assert property ((regRd || regWr) && ctl |=> ctrlSel)
    else $error("control select missing");
  ram_sel_a: assert property ((regRd || regWr) && !ctl |=> !ctrlSel)
    else $error("control select on low address");
  ctrl_wr_a: assert property (regWr && ctl |=> ctrlWr
    && ctrlAddr == $past(regAddr[7:0]) && ctrlWrData == $past(regWrData))
    else $error("control write wrong");
  ctrl_rd_a: assert property (regRd && ctl |=> ##1
    regRdData == $past(ctrlRdData)) else $error("control read wrong");
  hole_rd_a: assert property (regRd && 32'(regAddr) >= RAM_BYTES
    && !ctl |-> ##2 regRdData == 8'hff) else $error("hole read wrong");
  blank_rd_a: assert property (progRd && !ovl && big
    |-> ##2 progRdData == 8'hff) else $error("blank read wrong");
  flash_rd_a: assert property (progRd && !ovl && !big |=> ##1
    progRdData == $past(flashRdData)) else $error("flash read wrong");
  flash_wr_a: assert property (progWr && !ovl && !big |=> flashWr
    && flashAddr == $past(progAddr[12:0])) else $error("flash write lost");
  no_wr_a: assert property (progWr && (ovl || big) |=> !flashWr)
    else $error("write leaked to flash");
  pad_rd_a: assert property (progRd && ovl && progAddr >= 16'hfe49
    && progAddr <= 16'hfe53 |-> ##2 progRdData == 8'h0f)
    else $error("part pad wrong");
  info_hi_a: assert property (progRd && ovl && progAddr >= 16'hfe80
    |-> ##2 progRdData == 8'hff) else $error("overlay tail not blank");
  data_rd_a: assert property (!$past(srst) && !$past(srst, 2)
    |-> dataRdData == 8'hff) else $error("data read not blank");
endmodule
bind address_space_decoder addr_dec_props #(.RAM_BYTES(RAM_BYTES),
  .FLASH_BYTES(FLASH_BYTES)) u_props (.ref_clk, .srst, .regAddr, .regRd,
  .regWr, .regWrData, .regRdData, .ctrlSel, .ctrlWr, .ctrlAddr,
  .ctrlWrData, .ctrlRdData, .progAddr, .progRd, .progWr, .progRdData,
  .flashWr, .flashAddr, .flashRdData, .pageSelect, .dataRdData);
`default_nettype wire

// *** tb/flash_model.sv ***
/*
 Flash array and control register stand-in.
 Assumes registered flashAddr and ctrlAddr from the decoder.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_model (
  // Clock
  input wire logic        ref_clk,
  // Flash array side
  input wire logic        flashWr,
  input wire logic [12:0] flashAddr,
  input wire logic [7:0]  flashWrData,
  output logic     [7:0]  flashRdData,
  // Control register side
  input wire logic        ctrlSel,
  input wire logic [7:0]  ctrlAddr,
  output logic     [7:0]  ctrlRdData
);
  logic [7:0] mem [8192]; // Flash bytes
  logic [7:0] spin;       // Idle pattern
  // Seed contents with address pattern
  initial
  begin
    spin = 8'h00;
    for (int i = 0; i < 8192; i++) mem[i] = 8'(i) ^ 8'h5a;
  end
  // Store writes, churn idle pattern
  always @(posedge ref_clk)
  begin
    spin <= spin + 8'h01;
    if (flashWr) mem[flashAddr] <= flashWrData;
  end
  assign flashRdData = mem[flashAddr];
  // Unselected control bus shows a moving value
  assign ctrlRdData = ctrlSel ? (ctrlAddr ^ 8'ha5) : spin;
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
/*
 Self-checking bench for the address space decoder.
 Assumes flash_model and addr_dec_props compiled alongside.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic ref_clk = 0, srst = 1, regRd = 0, regWr = 0, ctrlSel, ctrlWr;
  logic progRd = 0, progWr = 0, flashWr, dataRd = 0, dataWr = 0;
  logic [11:0] regAddr = 0;
  logic [15:0] progAddr = 0, dataAddr = 0;
  logic [12:0] flashAddr;
  logic [7:0] regWrData = 0, regRdData, ctrlAddr, ctrlWrData, ctrlRdData;
  logic [7:0] progWrData = 0, progRdData, flashWrData, flashRdData;
  logic [7:0] pageSelect = 0, dataRdData;
  logic [2:0] progRegion;
  int err_count = 0, num_checks = 0;
  always #5 ref_clk = ~ref_clk;
  address_space_decoder uut (.ref_clk, .srst, .regAddr, .regRd, .regWr,
    .regWrData, .regRdData, .ctrlSel, .ctrlWr, .ctrlAddr, .ctrlWrData,
    .ctrlRdData, .progAddr, .progRd, .progWr, .progWrData, .progRdData,
    .flashWr, .flashAddr, .flashWrData, .flashRdData, .pageSelect,
    .dataAddr, .dataRd, .dataWr, .dataRdData, .progRegion);
  flash_model u_far (.ref_clk, .flashWr, .flashAddr, .flashWrData,
    .flashRdData, .ctrlSel, .ctrlAddr, .ctrlRdData);
  // Compare and count
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  // One register cycle, read checked two edges on
  task reg_acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    {regWr, regRd, regAddr, regWrData} = {w, !w, a, d};
    @(negedge ref_clk);
    {regWr, regRd} = 2'b00;
    @(negedge ref_clk);
    if (!w) chk("regRdData", d, regRdData);
  endtask
  // One program cycle with region check on reads
  task prg(input logic w, input logic [15:0] a, input logic [7:0] d,
           input logic [2:0] r);
    @(negedge ref_clk);
    {progWr, progRd, progAddr, progWrData} = {w, !w, a, d};
    @(negedge ref_clk);
    {progWr, progRd} = 2'b00;
    @(negedge ref_clk);
    if (!w) chk("progRdData", d, progRdData);
    if (!w) chk("progRegion", {5'h00, r}, {5'h00, progRegion});
  endtask
  // RAM ends, hole, control section
  task t_regs;
    reg_acc(1, 12'h000, 8'h3c);
    reg_acc(1, 12'h3ff, 8'hc3);
    reg_acc(1, 12'h400, 8'h99);
    reg_acc(0, 12'h000, 8'h3c);
    reg_acc(0, 12'h3ff, 8'hc3);
    reg_acc(0, 12'h400, 8'hff);
    reg_acc(0, 12'heff, 8'hff);
    reg_acc(1, 12'hf07, 8'h11);
    reg_acc(0, 12'hf55, 8'hf0);
    reg_acc(0, 12'hfff, 8'h5a);
  endtask
  // Vectors, code, beyond Flash
  task t_prog;
    prg(0, 16'h0001, 8'h5b, 3'(addr_dec_pkg::PR_OPTION));
    prg(0, 16'h0004, 8'h5e, 3'(addr_dec_pkg::PR_VECTOR));
    prg(0, 16'h0037, 8'h6d, 3'(addr_dec_pkg::PR_VECTOR));
    prg(0, 16'h003d, 8'h67, 3'(addr_dec_pkg::PR_VECTOR));
    prg(0, 16'h003e, 8'h64, 3'(addr_dec_pkg::PR_CODE));
    prg(1, 16'h0006, 8'h3c, 3'h0);
    prg(0, 16'h0006, 8'h3c, 3'(addr_dec_pkg::PR_VECTOR));
    prg(1, 16'h2000, 8'h00, 3'h0);
    prg(0, 16'h2000, 8'hff, 3'(addr_dec_pkg::PR_BLANK));
    prg(0, 16'h0000, 8'h5a, 3'(addr_dec_pkg::PR_OPTION));
  endtask
  // Overlay on, write attempt, then off
  task t_info;
    pageSelect = 8'h80;
    prg(0, 16'hfe40, 8'h41, 3'(addr_dec_pkg::PR_INFO));
    prg(0, 16'hfe49, 8'h0f, 3'(addr_dec_pkg::PR_INFO));
    prg(0, 16'hfe00, 8'hff, 3'(addr_dec_pkg::PR_INFO));
    prg(1, 16'hfe60, 8'h00, 3'h0);
    prg(0, 16'hfe60, 8'h80, 3'(addr_dec_pkg::PR_INFO));
    prg(0, 16'hff7f, 8'hff, 3'(addr_dec_pkg::PR_INFO));
    pageSelect = 8'h7f;
    prg(0, 16'hfe60, 8'hff, 3'(addr_dec_pkg::PR_BLANK));
  endtask
  // Mid-run reset clears the registered read data
  task t_reset;
    @(negedge ref_clk);
    srst = 1;
    @(negedge ref_clk);
    chk("regRdData", 8'h00, regRdData);
    chk("progRdData", 8'h00, progRdData);
    chk("dataRdData", 8'h00, dataRdData);
    srst = 0;
  endtask
  // Data space holds nothing
  task t_data;
    @(negedge ref_clk);
    {dataRd, dataWr, dataAddr} = {2'b01, 16'h0010};
    @(negedge ref_clk);
    {dataRd, dataWr} = 2'b10;
    @(negedge ref_clk);
    dataRd = 0;
    @(negedge ref_clk);
    chk("dataRdData", 8'hff, dataRdData);
  endtask
  // Verdict and end of run
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    #20000;
    err_count++;
    report_and_stop;
  end
  // Main sequence
  initial
  begin
    repeat (4) @(negedge ref_clk);
    srst = 0;
    t_regs;
    t_prog;
    t_info;
    t_reset;
    t_data;
    report_and_stop;
  end
endmodule
`default_nettype wire
